// *** hw/retrig_enc_pkg.sv ***
// Constants and types for the retriggerable pulse and quadrature counter
// Behaviour
// - Pulse starts at once on trigger
// - New trigger during pulse extends it
// - Compare mode 1000 variant 1, 1001 variant 2
// - Channel event flag meaningless in this mode
// - Mode fields stored split, top bit apart
// - Slave mode 001 B, 010 A, 011 both
// - Encoder counts only while run bit set
// - Direction updated on every input transition that moves one line only
// - Encoder count wraps between 0 and reload
// - Other timer functions keep working
// - Direction from edge and opposite level
// - Trigger reloads counter, updates, starts counting
package retrig_enc_pkg;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int MEM_DEPTH = 4;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_COUNT = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_RELOAD = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_COMPARE = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_POL = 4'h5;
   // Control word fields
   localparam int CTRL_RUN = 0;
   localparam int CTRL_DIR = 4;
   localparam int CTRL_CMS_LO = 5;
   localparam int CTRL_CMS_HI = 6;
   // Mode word: slave mode low three bits at 2:0, top bit at 16;
   // compare mode low three bits at 6:4, top bit at 24
   localparam int SMS_LO = 0;
   localparam int SMS_HI = 2;
   localparam int SMS_TOP = 16;
   localparam int OCM_LO = 4;
   localparam int OCM_HI = 6;
   localparam int OCM_TOP = 24;
   // Polarity word
   localparam int POL_A = 1;
   localparam int POL_AN = 3;
   localparam int POL_B = 5;
   localparam int POL_BN = 7;
   localparam logic [3:0] SMS_ENC_B = 4'h1;
   localparam logic [3:0] SMS_ENC_A = 4'h2;
   localparam logic [3:0] SMS_ENC_AB = 4'h3;
   localparam logic [3:0] SMS_RST_TRIG = 4'h8;
   localparam logic [3:0] OCM_RETRIG1 = 4'h8;
   localparam logic [3:0] OCM_RETRIG2 = 4'h9;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] RELOAD_RST = 16'hffff;
   typedef enum logic [1:0] {MODE_IDLE, MODE_ENCODER, MODE_PULSE} mode_t;
endpackage : retrig_enc_pkg

// *** hw/reg_store.sv ***
// Small register memory with registered read data
`timescale 1ns/10ps
module reg_store
   import retrig_enc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic wrEn,
   input wire logic [1:0] wrIdx,
   input wire logic [DATA_W-1:0] wrData,
   input wire logic [1:0] rdIdx,
   output logic [DATA_W-1:0] rdData,
   output logic [DATA_W-1:0] word0,
   output logic [DATA_W-1:0] word1
);
   logic [DATA_W-1:0] mem_q [MEM_DEPTH];

   generate
      for (genvar i = 0; i < MEM_DEPTH; i++)
      begin : g_word
         always_ff @(posedge sys_clk)
         begin
            if (rst)
               mem_q[i] <= '0;
            else if (clkEn && wrEn && wrIdx == 2'(i))
               mem_q[i] <= wrData;
         end
      end
   endgenerate

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         rdData <= '0;
      else if (clkEn)
         rdData <= mem_q[rdIdx];
   end

   assign word0 = mem_q[0];
   assign word1 = mem_q[1];
endmodule : reg_store

// *** hw/retrig_enc_counter.sv ***
// Retriggerable one-pulse and quadrature encoder counter core
`timescale 1ns/10ps
module retrig_enc_counter
   import retrig_enc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdData,
   input wire logic selectedTriggerInput,
   input wire logic filteredInputA,
   input wire logic filteredInputB,
   output logic pulseOut,
   output logic updateEvent,
   output logic channelEventFlag
);
   logic runBit_q;
   logic dir_q;
   logic [1:0] centerAlignSelect_q;
   logic [CNT_W-1:0] count_q;
   logic [DATA_W-1:0] modeWord;
   logic [DATA_W-1:0] polWord;
   logic [DATA_W-1:0] storeRd;
   logic storeSel_q;
   logic [DATA_W-1:0] directRd_q;
   logic [3:0] slaveModeSelect;
   logic [3:0] outputCompareMode;
   logic [CNT_W-1:0] autoReloadValue_q;
   logic [CNT_W-1:0] channelCompareValue_q;
   logic polA, polB;
   logic encA, encB, encA_q, encB_q, trig_q;
   logic edgeA, edgeB, trigRise;
   logic encMode, pulseMode, countA, countB;
   logic stepValid, stepUp;
   logic refLevel;
   mode_t mode;

   // Split mode fields: top bit kept apart for compatibility
   function automatic logic [3:0] joinField(input logic top,
                                            input logic [2:0] low);
      joinField = {top, low};
   endfunction : joinField

   function automatic logic storeIdx(input logic [ADDR_W-1:0] a);
      storeIdx = (a == ADDR_MODE) || (a == ADDR_POL);
   endfunction : storeIdx

   // Mode and polarity words live in the small store
   reg_store u_store (
      .sys_clk(sys_clk),
      .rst(rst),
      .clkEn(clkEn),
      .wrEn(regWr && storeIdx(regAddr)),
      .wrIdx(regAddr == ADDR_MODE ? 2'h0 : 2'h1),
      .wrData(regWrData),
      .rdIdx(regAddr == ADDR_MODE ? 2'h0 : 2'h1),
      .rdData(storeRd),
      .word0(modeWord),
      .word1(polWord)
   );

   assign slaveModeSelect = joinField(modeWord[SMS_TOP],
                                      modeWord[SMS_HI:SMS_LO]);
   assign outputCompareMode = joinField(modeWord[OCM_TOP],
                                        modeWord[OCM_HI:OCM_LO]);
   assign polA = polWord[POL_A];
   assign polB = polWord[POL_B];

   always_comb
   begin
      case (slaveModeSelect)
         SMS_ENC_A, SMS_ENC_B, SMS_ENC_AB: mode = MODE_ENCODER;
         SMS_RST_TRIG: mode = MODE_PULSE;
         default: mode = MODE_IDLE;
      endcase
   end

   assign encMode = (mode == MODE_ENCODER);
   assign pulseMode = (mode == MODE_PULSE);
   assign countA = (slaveModeSelect == SMS_ENC_A)
      || (slaveModeSelect == SMS_ENC_AB);
   assign countB = (slaveModeSelect == SMS_ENC_B)
      || (slaveModeSelect == SMS_ENC_AB);

   // Polarity select; complement bits are ignored in encoder use
   assign encA = filteredInputA ^ polA;
   assign encB = filteredInputB ^ polB;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         encA_q <= 1'b0;
         encB_q <= 1'b0;
         trig_q <= 1'b0;
      end
      else if (clkEn)
      begin
         encA_q <= encA;
         encB_q <= encB;
         trig_q <= selectedTriggerInput;
      end
   end

   assign edgeA = encA ^ encA_q;
   assign edgeB = encB ^ encB_q;
   assign trigRise = selectedTriggerInput && !trig_q;

   // Both edges at once is ambiguous, so it is dropped
   always_comb
   begin
      stepValid = 1'b0;
      stepUp = dir_q;
      if (edgeA && !edgeB)
      begin
         stepValid = countA;
         stepUp = (encA != encB);
      end
      else if (edgeB && !edgeA)
      begin
         stepValid = countB;
         stepUp = (encA == encB);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         dir_q <= 1'b0;
      else if (clkEn && regWr && regAddr == ADDR_CTRL)
         dir_q <= regWrData[CTRL_DIR];
      else if (clkEn && encMode && (edgeA ^ edgeB))
         dir_q <= !stepUp;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         runBit_q <= 1'b0;
         centerAlignSelect_q <= 2'b00;
      end
      else if (clkEn)
      begin
         if (regWr && regAddr == ADDR_CTRL)
         begin
            runBit_q <= regWrData[CTRL_RUN];
            centerAlignSelect_q <= regWrData[CTRL_CMS_HI:CTRL_CMS_LO];
         end
         if (pulseMode && trigRise)
            runBit_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         autoReloadValue_q <= RELOAD_RST;
         channelCompareValue_q <= CNT_ZERO;
      end
      else if (clkEn && regWr)
      begin
         if (regAddr == ADDR_RELOAD)
            autoReloadValue_q <= regWrData[CNT_W-1:0];
         if (regAddr == ADDR_COMPARE)
            channelCompareValue_q <= regWrData[CNT_W-1:0];
      end
   end

   // Counter: encoder steps, or pulse timing on the kernel clock
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         count_q <= CNT_ZERO;
      else if (clkEn)
      begin
         if (regWr && regAddr == ADDR_COUNT)
            count_q <= regWrData[CNT_W-1:0];
         else if (pulseMode && trigRise)
            // Restart extends a running pulse
            count_q <= dir_q ? autoReloadValue_q : CNT_ZERO;
         else if (encMode && runBit_q && stepValid)
         begin
            if (stepUp)
               count_q <= (count_q >= autoReloadValue_q) ? CNT_ZERO
                  : count_q + CNT_ONE;
            else
               count_q <= (count_q == CNT_ZERO) ? autoReloadValue_q
                  : count_q - CNT_ONE;
         end
         else if (pulseMode && runBit_q)
         begin
            // Shot parks at its end point; wrapping would fire again
            if (!dir_q && count_q < autoReloadValue_q)
               count_q <= count_q + CNT_ONE;
            else if (dir_q && count_q != CNT_ZERO)
               count_q <= count_q - CNT_ONE;
         end
      end
   end

   // Update pulse on trigger only; the shot ends when the count parks at its end point
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         updateEvent <= 1'b0;
      else if (clkEn)
         updateEvent <= pulseMode && trigRise;
   end

   // Pulse level is high while the shot runs; no delay phase
   // Parked count above a lowered reload must not raise the level
   assign refLevel = pulseMode && (trigRise || (runBit_q && (dir_q
      ? count_q != CNT_ZERO : count_q < autoReloadValue_q)));

   always_comb
   begin
      case (outputCompareMode)
         OCM_RETRIG1: pulseOut = refLevel;
         OCM_RETRIG2: pulseOut = !refLevel;
         default: pulseOut = 1'b0;
      endcase
   end

   // Compare match flag; carries no meaning in pulse mode
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         channelEventFlag <= 1'b0;
      else if (clkEn)
         channelEventFlag <= (count_q == channelCompareValue_q);
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         storeSel_q <= 1'b0;
         directRd_q <= '0;
      end
      else if (clkEn && regRd)
      begin
         storeSel_q <= storeIdx(regAddr);
         case (regAddr)
            ADDR_CTRL: directRd_q <= DATA_W'({centerAlignSelect_q, dir_q,
                                               3'h0, runBit_q});
            ADDR_COUNT: directRd_q <= DATA_W'(count_q);
            ADDR_RELOAD: directRd_q <= DATA_W'(autoReloadValue_q);
            ADDR_COMPARE: directRd_q <= DATA_W'(channelCompareValue_q);
            default: directRd_q <= '0;
         endcase
      end
   end

   assign regRdData = storeSel_q ? storeRd : directRd_q;

   property p_pulse_now;
      @(posedge sys_clk) disable iff (rst)
      (pulseMode && trigRise && outputCompareMode == OCM_RETRIG1)
         |-> pulseOut;
   endproperty
   a_pulse_now: assert property (p_pulse_now)
      else $error("pulse not started on trigger");

   property p_retrig;
      @(posedge sys_clk) disable iff (rst)
      (clkEn && pulseMode && trigRise && !regWr)
         |=> count_q == (dir_q ? autoReloadValue_q : CNT_ZERO) && runBit_q;
   endproperty
   a_retrig: assert property (p_retrig)
      else $error("retrigger did not restart count");

   property p_var2;
      @(posedge sys_clk) disable iff (rst)
      (pulseMode && trigRise && outputCompareMode == OCM_RETRIG2)
         |-> !pulseOut;
   endproperty
   a_var2: assert property (p_var2)
      else $error("variant 2 not inverted");

   property p_run_gate;
      @(posedge sys_clk) disable iff (rst)
      (clkEn && encMode && !runBit_q && !regWr) |=> $stable(count_q);
   endproperty
   a_run_gate: assert property (p_run_gate)
      else $error("encoder counted while stopped");

   property p_both;
      @(posedge sys_clk) disable iff (rst)
      (clkEn && encMode && edgeA && edgeB && !regWr)
         |=> $stable(count_q) && $stable(dir_q);
   endproperty
   a_both: assert property (p_both)
      else $error("double change counted");

   property p_up;
      @(posedge sys_clk) disable iff (rst)
      (clkEn && encMode && runBit_q && stepValid && stepUp && !regWr
         && count_q < autoReloadValue_q) |=> count_q == $past(count_q) + 1;
   endproperty
   a_up: assert property (p_up)
      else $error("up step wrong");

   property p_wrap;
      @(posedge sys_clk) disable iff (rst)
      (clkEn && encMode && runBit_q && stepValid && !stepUp && !regWr
         && count_q == CNT_ZERO) |=> count_q == $past(autoReloadValue_q);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("down wrap wrong");

   property p_dir;
      @(posedge sys_clk) disable iff (rst)
      (clkEn && encMode && edgeA && !edgeB && !regWr)
         |=> dir_q == ($past(encA) == $past(encB));
   endproperty
   a_dir: assert property (p_dir)
      else $error("direction not updated");

   property p_trig_upd;
      @(posedge sys_clk) disable iff (rst)
      (clkEn && pulseMode && trigRise) |=> updateEvent;
   endproperty
   a_trig_upd: assert property (p_trig_upd)
      else $error("no update on trigger");

   property p_shot_end;
      @(posedge sys_clk) disable iff (rst)
      (clkEn && pulseMode && !trigRise && !regWr && runBit_q && !dir_q
         && count_q == autoReloadValue_q) |=> $stable(count_q);
   endproperty
   a_shot_end: assert property (p_shot_end)
      else $error("finished shot kept counting");

   c_pulse: cover property (@(posedge sys_clk) pulseMode && trigRise
      && runBit_q);
   c_enc_up: cover property (@(posedge sys_clk) encMode && stepValid
      && stepUp && runBit_q);
   c_enc_down: cover property (@(posedge sys_clk) encMode && stepValid
      && !stepUp && runBit_q);
endmodule : retrig_enc_counter

// *** testbench/enc_source_model.sv ***
// Quadrature encoder and trigger source facing the counter
`timescale 1ns/10ps
module enc_source_model
(
   input wire logic sys_clk,
   output logic phaseA,
   output logic phaseB,
   output logic trigger
);
   logic [1:0] idx = 2'h0;
   initial
   begin
      phaseA = 1'b0;
      phaseB = 1'b0;
      trigger = 1'b0;
   end
   // Step 1 forward, 3 back, 2 is a fault: both lines flip at once
   // Gray order 00,10,11,01 keeps one line moving per step
   task automatic move(input logic [1:0] inc, input int gap);
      @(posedge sys_clk);
      idx = idx + inc;
      phaseA <= idx[0] ^ idx[1];
      phaseB <= idx[1];
      // Gap of at least one edge, so callers see settled levels
      repeat (gap) @(posedge sys_clk);
   endtask : move
   // Called right after a clock edge only
   task automatic setTrig(input logic v);
      trigger <= v;
   endtask : setTrig
endmodule : enc_source_model

// *** testbench/retrig_enc_counter_tb.sv ***
// Self-checking bench for the pulse and encoder counter
`timescale 1ns/10ps
module retrig_enc_counter_tb
   import retrig_enc_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic clkEn = 1'b1;
   logic [ADDR_W-1:0] regAddr = 4'h0;
   logic [DATA_W-1:0] regWrData = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [DATA_W-1:0] regRdData;
   logic encA, encB, trigIn, pulseOut, updateEvent, evtFlag;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h0cabc0f5;

   always #50 sys_clk = ~sys_clk;

   retrig_enc_counter i_retrig_enc_counter (.sys_clk(sys_clk), .rst(rst),
      .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .selectedTriggerInput(trigIn), .filteredInputA(encA),
      .filteredInputB(encB), .pulseOut(pulseOut),
      .updateEvent(updateEvent), .channelEventFlag(evtFlag));
   enc_source_model i_enc_source_model (.sys_clk(sys_clk), .phaseA(encA),
      .phaseB(encB), .trigger(trigIn));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Top bit of each field lives apart from its low three bits
   function automatic logic [31:0] modeWord(input logic [3:0] slave_mode_select,
                                            input logic [3:0] ocm);
      return (32'(slave_mode_select[2:0]) << SMS_LO) | (32'(slave_mode_select[3]) << SMS_TOP)
         | (32'(ocm[2:0]) << OCM_LO) | (32'(ocm[3]) << OCM_TOP);
   endfunction : modeWord

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   task automatic chkWord(input logic [31:0] got, exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chkWord
   task automatic chkBit(input logic got, exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask : chkBit
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask : rd

   // Random walk of the encoder; both-line flips must leave no trace
   task automatic encRun(input logic [3:0] slave_mode_select, input logic [31:0] pol,
                         input logic run, input int steps);
      logic [15:0] rl, exp;
      logic [31:0] r, got;
      logic expDir, a0, b0, up, aE;
      rl = 16'h0003 + 16'(rnd() & 32'h7);
      wr(ADDR_RELOAD, 32'(rl));
      wr(ADDR_POL, pol);
      wr(ADDR_MODE, modeWord(slave_mode_select, 4'h0));
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_CTRL, 32'(run) << CTRL_RUN);
      exp = 16'h0;
      expDir = 1'b0;
      for (int i = 0; i < steps; i++)
      begin
         r = rnd();
         a0 = encA ^ pol[POL_A];
         b0 = encB ^ pol[POL_B];
         i_enc_source_model.move((r[7:4] == 4'h0) ? 2'h2 : {~r[0], 1'b1},
                                 1 + int'(r[3:1]));
         if (r[7:4] != 4'h0)
         begin
            aE = (encA ^ pol[POL_A]) != a0;
            up = aE ? ~(a0 ^ b0) : (a0 ^ b0);
            expDir = ~up;
            if (run && (slave_mode_select == SMS_ENC_AB || slave_mode_select == (aE ? SMS_ENC_A : SMS_ENC_B)))
               exp = up ? ((exp == rl) ? 16'h0 : exp + 16'h1)
                  : ((exp == 16'h0) ? rl : exp - 16'h1);
         end
      end
      repeat (2) @(posedge sys_clk);
      rd(ADDR_COUNT, got);
      chkWord(got, 32'(exp), "count");
      chkBit(evtFlag, exp == 16'h0, "event flag");
      if (run)
      begin
         rd(ADDR_CTRL, got);
         chkBit(got[CTRL_DIR], expDir, "direction");
      end
   endtask : encRun

   // One shot, retriggered after rt cycles when rt is not zero
   task automatic shot(input logic [3:0] ocm, input logic down, input int rt);
      logic [15:0] rl;
      logic act;
      int hi;
      rl = 16'h0005 + 16'(rnd() & 32'h7);
      act = (ocm == OCM_RETRIG1);
      wr(ADDR_RELOAD, 32'(rl));
      wr(ADDR_COMPARE, down ? 32'(rl) : 32'h0);
      wr(ADDR_CTRL, 32'(down) << CTRL_DIR);
      wr(ADDR_MODE, modeWord(SMS_RST_TRIG, ocm));
      @(posedge sys_clk);
      i_enc_source_model.setTrig(1'b1);
      #1 chkBit(pulseOut, act, "pulse start");
      hi = 0;
      for (int i = 1; i < rt + int'(rl) + 5; i++)
      begin
         @(posedge sys_clk);
         i_enc_source_model.setTrig(i == rt);
         #1;
         if (i < 3)
            chkBit(updateEvent, i == 1, "update");
         if (pulseOut === act)
            hi = i;
      end
      chkWord(32'(hi), 32'(rt + int'(rl)), "pulse length");
   endtask : shot

   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         complete_run();
      end
   end

   initial
   begin
      static int addrs[7] = '{0, 1, 2, 3, 4, 5, 15};
      logic [31:0] got;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (addrs[k])
      begin
         rd(4'(addrs[k]), got);
         chkWord(got, (4'(addrs[k]) == ADDR_RELOAD) ? 32'(RELOAD_RST) : 32'h0,
                 "reset value");
      end
      // Unmapped place ignores writes and reads zero
      wr(4'hf, 32'hffffffff);
      rd(4'hf, got);
      chkWord(got, 32'h0, "unmapped");
      // Writes while the clock enable is low must not land
      @(posedge sys_clk);
      clkEn <= 1'b0;
      wr(ADDR_COMPARE, 32'h00001234);
      clkEn <= 1'b1;
      rd(ADDR_COMPARE, got);
      chkWord(got, 32'h0, "frozen write");
      encRun(SMS_ENC_A, 32'h0, 1'b1, 60);
      encRun(SMS_ENC_B, 32'h0, 1'b1, 60);
      encRun(SMS_ENC_AB, 32'h0, 1'b1, 60);
      encRun(SMS_ENC_AB, 32'h1 << POL_A, 1'b1, 40);
      encRun(SMS_ENC_AB, 32'h0, 1'b0, 20);
      shot(OCM_RETRIG1, 1'b0, 0);
      shot(OCM_RETRIG2, 1'b0, 0);
      shot(OCM_RETRIG1, 1'b1, 4);
      shot(OCM_RETRIG2, 1'b1, 3);
      shot(OCM_RETRIG1, 1'b0, 3 + int'(rnd() & 32'h1));
      complete_run();
   end
endmodule : retrig_enc_counter_tb
